/* File: hw/trb_core.sv */
`timescale 1ns/1ns
`default_nettype none
`include "trb_defs.svh"
// core-side end: turns user requests into link accesses, registers the program rom word
module trb_core
  import trb_pkg::*;
#(
  parameter int TBL_AW  = `TRB_TBL_AW,
  parameter int PROG_DW = `TRB_PROG_DW
) (
  input  wire logic              i_ref_clk,
  input  wire logic              i_sys_rst,
  trb_if.core                    bus,
  input  wire trb_op_type        i_op,
  input  wire logic [7:0]        i_addr,
  input  wire logic [7:0]        i_wdata,
  input  wire logic [2:0]        i_bit_sel,
  input  wire logic              i_bit_val,
  input  wire logic              i_tbl_req,
  input  wire trb_tbl_type       i_tbl_kind,
  input  wire logic [7:0]        i_tbl_dest,
  input  wire logic [PROG_DW-1:0] i_rom_word,
  output logic                   o_ready,
  output logic [7:0]             o_rdata,
  output logic                   o_tbl_done,
  output logic [TBL_AW-1:0]      o_rom_addr
);
  ////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [PROG_DW-1:0] word;
  } trb_core_type;
  trb_core_type c_r;
  trb_core_type c_nxt;

  // requests held off while a table read is in flight
  assign o_ready      = !bus.busy;
  assign bus.op       = o_ready ? i_op : TRB_OP_NONE;
  assign bus.addr     = i_addr;
  assign bus.wdata    = i_wdata;
  assign bus.bit_sel  = i_bit_sel;
  assign bus.bit_val  = i_bit_val;
  assign bus.tbl_req  = o_ready && i_tbl_req;
  assign bus.tbl_kind = i_tbl_kind;
  assign bus.tbl_dest = i_tbl_dest;
  // last-page variant forces the page to all ones
  assign o_rom_addr = (i_tbl_kind == TRB_TBL_LAST) ?
                      {5'h1F, bus.pm_addr[7:0]} : bus.pm_addr;
  assign bus.pm_data = c_r.word;
  assign o_rdata    = bus.rdata;
  assign o_tbl_done = bus.tbl_done;

  // rom word registered every cycle; the transfer cycle sees the word of the request cycle
  always_comb begin
    c_nxt = c_r;
    c_nxt.word = i_rom_word;
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      c_r <= '0;
    end else begin
      c_r <= c_nxt;
    end
  end
endmodule : trb_core
`default_nettype wire

/* File: hw/trb_defs.svh */
`ifndef TRB_DEFS_SVH
`define TRB_DEFS_SVH
// data memory map
`define TRB_SFR_LAST      8'h7F
`define TRB_GPR_FIRST     8'h80
`define TRB_OFS_BANK_PTR  8'h04
`define TRB_OFS_TBL_LO    8'h07
`define TRB_OFS_TBL_HOLD  8'h08
`define TRB_OFS_TBL_HI    8'h09
`define TRB_OFS_NVM_CTRL  8'h40
`define TRB_NVM_BANK      2'h1
// widths and reset values
`define TRB_TBL_AW        13
`define TRB_PROG_DW       16
`define TRB_BANKS         4
`define TRB_GPR_BYTES     128
`define TRB_RST_BYTE      8'h00
// a table read occupies two instruction cycles
`define TRB_TABRD_CYCLES  2
`endif

/* File: hw/trb_if.sv */
`timescale 1ns/1ns
`default_nettype none
// core-to-memory link: data accesses, table reads, program memory port
interface trb_if;
  import trb_pkg::*;
  trb_op_type  op;
  logic [7:0]  addr;
  logic [7:0]  wdata;
  logic [2:0]  bit_sel;
  logic        bit_val;
  logic [7:0]  rdata;
  logic        tbl_req;
  trb_tbl_type tbl_kind;
  logic [7:0]  tbl_dest;
  logic        busy;
  logic        tbl_done;
  logic [12:0] pm_addr;
  logic [15:0] pm_data;
  modport mem (input op, addr, wdata, bit_sel, bit_val, tbl_req, tbl_kind,
               tbl_dest, pm_data,
               output rdata, busy, tbl_done, pm_addr);
  modport core (output op, addr, wdata, bit_sel, bit_val, tbl_req, tbl_kind,
                tbl_dest, pm_data,
                input rdata, busy, tbl_done, pm_addr);
endinterface : trb_if
`default_nettype wire

/* File: hw/trb_mem.sv */
`timescale 1ns/1ns
`default_nettype none
`include "trb_defs.svh"
module trb_mem
  import trb_pkg::*;
#(
  parameter int TBL_AW    = `TRB_TBL_AW,
  parameter int PROG_DW   = `TRB_PROG_DW,
  parameter int GPR_BYTES = `TRB_GPR_BYTES
) (
  input  wire logic i_ref_clk,
  input  wire logic i_sys_rst,
  trb_if.mem        bus,
  input  wire logic i_emul_mode,
  input  wire logic i_pin_pa0,
  input  wire logic i_pin_pa2,
  output logic      o_pa0_fn,
  output logic      o_pa2_fn,
  output logic [7:0] o_nvm_ctrl,
  output logic [1:0] o_bank
);
  ////////////////////////////////////////////////////////////////////////
  typedef enum logic {ST_IDLE, ST_XFER} trb_st_type;
  typedef struct packed {
    trb_st_type  st;
    logic [7:0]  tbl_lo;
    logic [7:0]  tbl_hi;
    logic [7:0]  tbl_hold;
    logic [7:0]  bank_ptr;
    logic [7:0]  nvm_ctrl;
    logic [7:0]  rdata;
    logic [7:0]  dest;
    logic        done;
  } trb_state_type;

  trb_state_type s_r;
  trb_state_type s_nxt;
  logic [7:0]    gpr_mem [`TRB_BANKS*GPR_BYTES];
  logic [8:0]    gpr_idx;
  logic [7:0]    gpr_q;
  logic          gpr_we;
  logic [7:0]    gpr_wd;
  logic [7:0]    cur;
  logic [7:0]    wbyte;
  logic          is_gpr;
  logic [7:0]    hi_byte;
  logic [7:0]    lo_byte;
  // ram write port: bank in index bits 8:7, offset in bits 6:0
  logic [8:0]    gpr_waddr;

  ////////////////////////////////////////////////////////////////////////
  // general area: bank in the top index bits
  assign is_gpr  = bus.addr >= `TRB_GPR_FIRST;
  assign gpr_idx = {s_r.bank_ptr[1:0], bus.addr[6:0]};
  assign gpr_q   = gpr_mem[gpr_idx];
  assign bus.pm_addr = {s_r.tbl_hi[TBL_AW-9:0], s_r.tbl_lo};
  assign lo_byte = bus.pm_data[7:0];
  // unfilled high bits padded with zero: a program word narrower than
  // sixteen bits leaves the top holder bits clear
  assign hi_byte = 8'(bus.pm_data[PROG_DW-1:8]);

  // current byte of any location, for bit operations
  function automatic logic [7:0] rd_byte(input trb_state_type s,
                                         input logic [7:0] a,
                                         input logic [7:0] g);
    logic [7:0] v;
    v = `TRB_RST_BYTE;
    if (a >= `TRB_GPR_FIRST) begin
      v = g;
    end else begin
      unique case (a)
        `TRB_OFS_BANK_PTR: v = s.bank_ptr;
        `TRB_OFS_TBL_LO:   v = s.tbl_lo;
        `TRB_OFS_TBL_HOLD: v = s.tbl_hold;
        `TRB_OFS_TBL_HI:   v = s.tbl_hi;
        // control register hides outside bank 1, reads like unused space
        `TRB_OFS_NVM_CTRL: v = (s.bank_ptr[1:0] == `TRB_NVM_BANK) ?
                               s.nvm_ctrl : `TRB_RST_BYTE;
        default:           v = `TRB_RST_BYTE;
      endcase
    end
    return v;
  endfunction : rd_byte

  ////////////////////////////////////////////////////////////////////////
  // next state and memory write request; one access per cycle, and a
  // table request outranks a data op presented beside it
  always_comb begin
    s_nxt  = s_r;
    s_nxt.done = 1'b0;
    gpr_we = 1'b0;
    // write port address: data op offset, or table destination later
    gpr_waddr = gpr_idx;
    gpr_wd = lo_byte;
    cur    = rd_byte(s_r, bus.addr, gpr_q);
    wbyte  = bus.wdata;
    if (bus.op == TRB_OP_BIT) begin
      wbyte = cur;
      wbyte[bus.bit_sel] = bus.bit_val;
    end
    unique case (s_r.st)
      ST_IDLE: begin
        if (bus.tbl_req) begin
          s_nxt.st   = ST_XFER;
          s_nxt.dest = bus.tbl_dest;
        end else if (bus.op == TRB_OP_READ) begin
          s_nxt.rdata = cur;
        end else if (bus.op == TRB_OP_WRITE || bus.op == TRB_OP_BIT) begin
          if (is_gpr) begin
            gpr_we = 1'b1;
            gpr_wd = wbyte;
          end else begin
            // holder read-only: writes to it are dropped
            // bank pointer keeps two bits, the upper ones read back zero
            unique case (bus.addr)
              `TRB_OFS_BANK_PTR: s_nxt.bank_ptr = {6'h00, wbyte[1:0]};
              `TRB_OFS_TBL_HOLD: ;
              `TRB_OFS_TBL_LO:   s_nxt.tbl_lo = wbyte;
              `TRB_OFS_TBL_HI:   s_nxt.tbl_hi = wbyte;
              `TRB_OFS_NVM_CTRL: if (s_r.bank_ptr[1:0] == `TRB_NVM_BANK)
                                   s_nxt.nvm_ctrl = wbyte;
              default: ;
            endcase
          end
        end
      end
      ST_XFER: begin
        // second cycle: both halves land together; the holder has no
        // save path, so a table read in a handler clobbers main code's
        // value unless software keeps interrupts off around its reads
        s_nxt.st       = ST_IDLE;
        s_nxt.tbl_hold = hi_byte;
        s_nxt.done     = 1'b1;
        s_nxt.rdata    = lo_byte;
        if (s_r.dest >= `TRB_GPR_FIRST) begin
          gpr_we = 1'b1;
          gpr_wd = lo_byte;
          gpr_waddr = {s_r.bank_ptr[1:0], s_r.dest[6:0]};
        end else begin
          unique case (s_r.dest)
            `TRB_OFS_BANK_PTR: s_nxt.bank_ptr = {6'h00, lo_byte[1:0]};
            // high byte load of this same cycle wins over the low byte
            `TRB_OFS_TBL_HOLD: ;
            `TRB_OFS_TBL_LO:   s_nxt.tbl_lo = lo_byte;
            `TRB_OFS_TBL_HI:   s_nxt.tbl_hi = lo_byte;
            `TRB_OFS_NVM_CTRL: if (s_r.bank_ptr[1:0] == `TRB_NVM_BANK)
                                 s_nxt.nvm_ctrl = lo_byte;
            default: ;
          endcase
        end
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // state register
  // sync reset clears pointers, holder, bank and control register
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // banked general ram, not reset (volatile)
  always_ff @(posedge i_ref_clk) begin
    if (gpr_we && !i_sys_rst) begin
      gpr_mem[gpr_waddr] <= gpr_wd;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // link outputs come straight from the state register; the core masks
  // data ops while busy, so nothing collides with the table write port
  assign bus.rdata    = s_r.rdata;
  assign bus.busy     = (s_r.st == ST_XFER);
  assign bus.tbl_done = s_r.done;
  assign o_nvm_ctrl   = s_r.nvm_ctrl;
  assign o_bank       = s_r.bank_ptr[1:0];

  // pa0 and pa2 also serve the programming link as data and clock;
  // its serial protocol sits outside this block
  // debug variant: shared pin functions forced off
  assign o_pa0_fn = i_emul_mode ? 1'b0 : i_pin_pa0;
  assign o_pa2_fn = i_emul_mode ? 1'b0 : i_pin_pa2;
endmodule : trb_mem
`default_nettype wire

/* File: hw/trb_pkg.sv */
package trb_pkg;
  typedef enum logic [1:0] {
    TRB_OP_NONE,
    TRB_OP_READ,
    TRB_OP_WRITE,
    TRB_OP_BIT
  } trb_op_type;
  typedef enum logic {
    TRB_TBL_CUR,
    TRB_TBL_LAST
  } trb_tbl_type;
endpackage : trb_pkg

/* File: tb/tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
// drives the core end, answers its rom port, checks both user sides
module tb_top;
  import trb_pkg::*;
  typedef struct packed {
    trb_tbl_type k;
    logic [7:0]  hi, lo, dst;
    logic [12:0] pa;
  } trb_row_type;
  // row 2 sets spare pointer bits, row 3 uses the last-page variant
  trb_row_type rows [4] = '{
    '{TRB_TBL_CUR, 8'h1F, 8'h06, 8'h80, 13'h1F06},
    '{TRB_TBL_CUR, 8'hE3, 8'hFF, 8'hFF, 13'h03FF},
    '{TRB_TBL_LAST, 8'h00, 8'h05, 8'h81, 13'h1F05},
    '{TRB_TBL_CUR, 8'h00, 8'h00, 8'h90, 13'h0000}};
  logic        i_ref_clk = 1'b0, i_sys_rst = 1'b1;
  trb_op_type  i_op = TRB_OP_NONE;
  logic [7:0]  i_addr = 8'h00, i_wdata = 8'h00, i_tbl_dest = 8'h00;
  logic [2:0]  i_bit_sel = 3'h0;
  logic        i_bit_val = 1'b0, i_tbl_req = 1'b0;
  trb_tbl_type i_tbl_kind = TRB_TBL_CUR;
  logic        i_emul_mode = 1'b0, i_pin_pa0 = 1'b1, i_pin_pa2 = 1'b1;
  logic        o_ready, o_tbl_done, o_pa0_fn, o_pa2_fn;
  logic [7:0]  o_rdata, o_nvm_ctrl;
  logic [1:0]  o_bank;
  logic [12:0] o_rom_addr;
  logic [15:0] i_rom_word;
  int          error_cnt = 0, samples_checked = 0, cyc = 0;
  trb_if link ();
  trb_core trb_core_inst (.i_ref_clk, .i_sys_rst, .bus(link), .i_op,
    .i_addr, .i_wdata, .i_bit_sel, .i_bit_val, .i_tbl_req, .i_tbl_kind,
    .i_tbl_dest, .i_rom_word, .o_ready, .o_rdata, .o_tbl_done, .o_rom_addr);
  trb_mem trb_mem_inst (.i_ref_clk, .i_sys_rst, .bus(link), .i_emul_mode,
    .i_pin_pa0, .i_pin_pa2, .o_pa0_fn, .o_pa2_fn, .o_nvm_ctrl, .o_bank);
  trb_props trb_props_inst (.i_ref_clk, .i_sys_rst, .op(link.op),
    .addr(link.addr), .wdata(link.wdata), .rdata(link.rdata),
    .tbl_req(link.tbl_req), .busy(link.busy), .tbl_done(link.tbl_done),
    .pm_addr(link.pm_addr), .pm_data(link.pm_data));
  // rom contents: low byte depends on the whole address, high byte on its low eight bits
  function automatic logic [15:0] rom_w(input logic [12:0] a);
    return {~a[7:0], a[7:0] ^ {3'h0, a[12:8]}};
  endfunction : rom_w
  assign i_rom_word = rom_w(o_rom_addr);
  always #50 i_ref_clk = ~i_ref_clk;
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [15:0] e, g);
    samples_checked++;
    if (g !== e) begin
      $display("MISMATCH %s expected %h seen %h", n, e, g);
      error_cnt++;
    end
  endtask : chk
  // one idle cycle between requests keeps o_ready high at the take edge
  task automatic acc(input trb_op_type o, input logic [7:0] a, d);
    @(posedge i_ref_clk);
    i_op <= o;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_ref_clk);
    i_op <= TRB_OP_NONE;
    #1;
  endtask : acc
  task automatic rd(input logic [7:0] a, e, input string n);
    acc(TRB_OP_READ, a, 8'h00);
    chk(n, {8'h00, e}, {8'h00, o_rdata});
  endtask : rd
  // kind stays held to the end, the core samples rom a cycle late
  task automatic tab(input trb_tbl_type k, input logic [7:0] d,
                     input logic [15:0] w);
    @(posedge i_ref_clk);
    i_tbl_req <= 1'b1;
    i_tbl_kind <= k;
    i_tbl_dest <= d;
    @(posedge i_ref_clk);
    i_tbl_req <= 1'b0;
    #1;
    chk("ready", 16'h0000, {15'h0, o_ready});
    @(posedge i_ref_clk);
    #1;
    chk("done", 16'h0001, {15'h0, o_tbl_done});
    chk("low", {8'h00, w[7:0]}, {8'h00, o_rdata});
  endtask : tab
  task automatic complete_run();
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : complete_run
  // hang guard, far above the roughly 135 cycles needed
  always @(posedge i_ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      error_cnt++;
      complete_run();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // table rows, then banking, bit ops, pins and a mid-run reset
  initial begin
    logic [15:0] w;
    repeat (4) @(posedge i_ref_clk);
    i_sys_rst <= 1'b0;
    foreach (rows[i]) begin
      w = rom_w(rows[i].pa);
      acc(TRB_OP_WRITE, 8'h09, rows[i].hi);
      acc(TRB_OP_WRITE, 8'h07, rows[i].lo);
      tab(rows[i].k, rows[i].dst, w);
      chk("rom_addr", {3'h0, rows[i].pa}, {3'h0, o_rom_addr});
      rd(rows[i].dst, w[7:0], "dest");
      rd(8'h08, w[15:8], "holder");
      acc(TRB_OP_WRITE, 8'h08, ~w[15:8]);
      rd(8'h08, w[15:8], "holder_ro");
    end
    for (int b = 0; b < 4; b++) begin
      acc(TRB_OP_WRITE, 8'h04, 8'(b));
      acc(TRB_OP_WRITE, 8'hA0, 8'h10 + 8'(b));
    end
    for (int b = 3; b >= 0; b--) begin
      acc(TRB_OP_WRITE, 8'h04, 8'(b));
      chk("bank", 16'(b), {14'h0, o_bank});
      rd(8'hA0, 8'h10 + 8'(b), "gpr");
      acc(TRB_OP_WRITE, 8'h40, 8'h5A);
      rd(8'h40, (b == 1) ? 8'h5A : 8'h00, "nvm");
    end
    chk("nvm_out", 16'h005A, {8'h00, o_nvm_ctrl});
    rd(8'h07, 8'h00, "ptr_lo");
    acc(TRB_OP_WRITE, 8'hB0, 8'hC3);
    @(posedge i_ref_clk);
    i_bit_sel <= 3'h2;
    i_bit_val <= 1'b1;
    acc(TRB_OP_BIT, 8'hB0, 8'h00);
    @(posedge i_ref_clk);
    i_bit_sel <= 3'h0;
    i_bit_val <= 1'b0;
    acc(TRB_OP_BIT, 8'hB0, 8'h00);
    rd(8'hB0, 8'hC6, "bit_op");
    acc(TRB_OP_WRITE, 8'h7F, 8'hFF);
    rd(8'h7F, 8'h00, "unused");
    for (int e = 0; e < 2; e++) begin
      @(posedge i_ref_clk);
      i_emul_mode <= e[0];
      #1;
      chk("pin_fn", {14'h0, ~e[0], ~e[0]}, {14'h0, o_pa0_fn, o_pa2_fn});
    end
    @(posedge i_ref_clk);
    i_sys_rst <= 1'b1;
    @(posedge i_ref_clk);
    i_sys_rst <= 1'b0;
    #1;
    chk("rst_regs", 16'h0000, {6'h0, o_bank, o_nvm_ctrl});
    rd(8'h08, 8'h00, "rst_holder");
    complete_run();
  end
endmodule : tb_top
`default_nettype wire

/* File: tb/trb_props.sv */
`timescale 1ns/1ns
`default_nettype none
// watches the core-to-memory link against shadows of key registers
module trb_props
  import trb_pkg::*;
(
  input wire logic        i_ref_clk,
  input wire logic        i_sys_rst,
  input wire trb_op_type  op,
  input wire logic [7:0]  addr,
  input wire logic [7:0]  wdata,
  input wire logic [7:0]  rdata,
  input wire logic        tbl_req,
  input wire logic        busy,
  input wire logic        tbl_done,
  input wire logic [12:0] pm_addr,
  input wire logic [15:0] pm_data
);
  logic [7:0] lo_r, hi_r, hold_r;
  logic [1:0] bank_r;
  logic       rd, wr;
  assign rd = (op == TRB_OP_READ) && !busy;
  assign wr = (op == TRB_OP_WRITE) && !busy;
  // shadows; bit ops on these offsets are not tracked
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      lo_r   <= 8'h00;
      hi_r   <= 8'h00;
      hold_r <= 8'h00;
      bank_r <= 2'h0;
    end else begin
      lo_r   <= (wr && addr == 8'h07) ? wdata : lo_r;
      hi_r   <= (wr && addr == 8'h09) ? wdata : hi_r;
      bank_r <= (wr && addr == 8'h04) ? wdata[1:0] : bank_r;
      hold_r <= busy ? pm_data[15:8] : hold_r;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);
  a_tbl_two_cycle:
    assert property (tbl_req && !busy |=> busy ##1 tbl_done)
    else $error("table read late");
  a_done_pulse:
    assert property (tbl_done |=> !tbl_done) else $error("done too long");
  a_busy_once:
    assert property (busy |=> !busy && tbl_done) else $error("busy too long");
  a_low_byte:
    assert property (busy |=> rdata == $past(pm_data[7:0]))
    else $error("low byte wrong");
  a_addr_ptr:
    assert property (tbl_req && !busy |-> pm_addr == {hi_r[4:0], lo_r})
    else $error("table address wrong");
  a_holder_read:
    assert property (rd && addr == 8'h08 |=> rdata == hold_r)
    else $error("holder wrong");
  a_unused_zero:
    assert property (rd && !addr[7] &&
      !(addr inside {8'h04, 8'h07, 8'h08, 8'h09, 8'h40}) |=> rdata == 8'h00)
    else $error("unused not zero");
  a_nvm_bank:
    assert property (rd && addr == 8'h40 && bank_r != 2'h1 |=> rdata == 8'h00)
    else $error("nvm seen off bank");
  a_ptr_shared:
    assert property (rd && addr == 8'h07 |=> rdata == lo_r)
    else $error("pointer read wrong");
  c_table: cover property (tbl_done);
  c_nvm: cover property (rd && addr == 8'h40 && bank_r == 2'h1);
  c_bit: cover property (op == TRB_OP_BIT && !busy);
endmodule : trb_props
`default_nettype wire
